// File: aps_port_setup.sv
// pin routing, clock and option setup for the cell-bus / serial cell port
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module aps_port_setup #(
	parameter logic [3:0] TRANSPARENT_MODE = 4'h1
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [aps_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [aps_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [aps_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [17:15] pb_in,
	output logic [21:20] pb_out,
	output logic [21:20] pb_oe,
	input wire logic pc15_in,
	input wire logic [15:3] pd_in,
	output logic [15:3] pd_out,
	output logic [15:3] pd_oe,
	input wire logic [7:0] cell_tx_data,
	input wire logic cell_tx_data_en,
	output logic [7:0] cell_rx_data,
	input wire logic soc_tx,
	input wire logic soc_tx_en,
	output logic soc_rx,
	input wire logic core_rx_enb,
	input wire logic core_tx_enb,
	input wire logic [1:0] core_phy_select,
	output logic tx_cav,
	output logic rx_cav,
	output logic [1:0] phy_request,
	input wire logic [15:3] ser_pd_out,
	input wire logic [15:3] ser_pd_oe,
	output logic [15:3] periph_pd_in,
	output logic cell_bus_clock,
	output logic sar_on,
	output logic cell_bus_mode,
	output logic request0_mode,
	output logic request1_mode,
	output logic [1:0] request_priority,
	output logic cell_ctrl_tx,
	output logic cell_ctrl_rx,
	output logic transparent_tx,
	output logic transparent_rx,
	output logic payload_whitening_on,
	output logic coset_on,
	output logic cell_sync_flag
);
	import aps_pkg::*;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// pin carrying cell data bit i
	function automatic int data_pin(input int i);
		data_pin = (i < 4) ? (15 - i) : (11 - i);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// registers (msb-first numbering to match pin numbers; own registers lsb-first)

	logic [0:31] sys_clock_control_reg;
	logic [0:15] protocol_mode_reg;
	logic [0:31] portb_assign_reg;
	logic [0:31] portb_direction_reg;
	logic [0:15] portc_assign_reg;
	logic [0:15] portc_direction_reg;
	logic [0:15] portc_special_option_reg;
	logic [0:15] portd_assign_reg;
	logic [0:15] portd_direction_reg;
	logic [0:15] portd_data_reg;
	logic [3:0] processor_config_reg;
	logic cav_mask_reg;
	logic [5:0] channel_general_mode_reg;
	logic [15:0] max_rx_buffer_len_reg;
	logic [4:0] settle_reg;
	logic sync_reg;
	logic [DATA_W-1:0] rdata_next;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sys_clock_control_reg <= SYS_CLOCK_CONTROL_RST;
			protocol_mode_reg <= PROTOCOL_MODE_RST;
			portb_assign_reg <= '0;
			portb_direction_reg <= '0;
			portc_assign_reg <= '0;
			portc_direction_reg <= '0;
			portc_special_option_reg <= '0;
			portd_assign_reg <= '0;
			portd_direction_reg <= '0;
			portd_data_reg <= '0;
			processor_config_reg <= '0;
			cav_mask_reg <= 1'b0;
			channel_general_mode_reg <= '0;
			max_rx_buffer_len_reg <= '0;
		end else if (reg_wr) begin
			if (hit(reg_addr, OFS_SYS_CLOCK_CONTROL))
				sys_clock_control_reg <= reg_wdata;
			if (hit(reg_addr, OFS_PROTOCOL_MODE))
				protocol_mode_reg <= reg_wdata[15:0];
			if (hit(reg_addr, OFS_PORTB_ASSIGN))
				portb_assign_reg <= reg_wdata;
			if (hit(reg_addr, OFS_PORTB_DIRECTION))
				portb_direction_reg <= reg_wdata;
			if (hit(reg_addr, OFS_PORTC_ASSIGN))
				portc_assign_reg <= reg_wdata[15:0];
			if (hit(reg_addr, OFS_PORTC_DIRECTION))
				portc_direction_reg <= reg_wdata[15:0];
			if (hit(reg_addr, OFS_PORTC_SPECIAL_OPTION))
				portc_special_option_reg <= reg_wdata[15:0];
			if (hit(reg_addr, OFS_PORTD_ASSIGN))
				portd_assign_reg <= reg_wdata[15:0];
			if (hit(reg_addr, OFS_PORTD_DIRECTION))
				portd_direction_reg <= reg_wdata[15:0];
			if (hit(reg_addr, OFS_PORTD_DATA))
				portd_data_reg <= reg_wdata[15:0];
			if (hit(reg_addr, OFS_PROCESSOR_CONFIG))
				processor_config_reg <= reg_wdata[3:0];
			if (hit(reg_addr, OFS_REFRESH_CONTROL))
				cav_mask_reg <= reg_wdata[0];
			if (hit(reg_addr, OFS_CHANNEL_GENERAL_MODE))
				channel_general_mode_reg <= reg_wdata[5:0];
			if (hit(reg_addr, OFS_MAX_RX_BUFFER_LEN))
				max_rx_buffer_len_reg <= reg_wdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode decode

	logic cell_mode;
	logic serial_cell_cfg;
	logic mphy_req_ok;
	logic mphy_sel_ok;

	always_comb begin
		// select bit only takes effect with the segmentation engine on
		cell_mode = portd_assign_reg[SAR_BIT] & portd_assign_reg[CELL_SEL_BIT];
		// one mode field serves both directions, so mixed use cannot arise
		serial_cell_cfg = portd_assign_reg[SAR_BIT] & ~portd_assign_reg[CELL_SEL_BIT]
			& (channel_general_mode_reg[MODE_HI:0] == TRANSPARENT_MODE)
			& (max_rx_buffer_len_reg == '0);
		// multi-phy pins work only in cell-bus mode
		mphy_req_ok = cell_mode;
		mphy_sel_ok = cell_mode;
	end

	////////////////////////////////////////////////////////////////////////////
	// settle counter and sync hunt

	// counts down the settle window after each port D assignment write
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			settle_reg <= '0;
		end else if (reg_wr && hit(reg_addr, OFS_PORTD_ASSIGN)) begin
			settle_reg <= SETTLE_CYC;
		end else if (settle_reg != '0) begin
			settle_reg <= 5'(settle_reg - 5'h01);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync_reg <= 1'b0;
		end else if (!cell_mode || cav_mask_reg) begin
			sync_reg <= 1'b0;
		end else if (pd_in[PD_SOC] && portd_assign_reg[PD_SOC]) begin
			sync_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// port D pin routing

	logic [15:3] pd_out_next;
	logic [15:3] pd_oe_next;
	logic [15:3] periph_next;
	logic [7:0] rx_data_next;

	genvar k;
	generate
		for (k = 3; k <= 15; k++) begin : g_pd
			always_comb begin
				pd_out_next[k] = ser_pd_out[k];
				pd_oe_next[k] = ser_pd_oe[k];
				periph_next[k] = pd_in[k];
				if (!portd_assign_reg[k]) begin
					pd_out_next[k] = portd_data_reg[k];
					pd_oe_next[k] = portd_direction_reg[k];
				end else if (cell_mode && PD_CELL_PINS[k]) begin
					pd_out_next[k] = 1'b0;
					pd_oe_next[k] = 1'b0;
					if (PD_FORCE_LOW[k])
						periph_next[k] = 1'b0;
					if (PD_FORCE_HIGH[k])
						periph_next[k] = 1'b1;
					if (k == PD_RXENB) begin
						pd_out_next[k] = core_rx_enb;
						pd_oe_next[k] = 1'b1;
					end
					if (k == PD_TXENB) begin
						pd_out_next[k] = core_tx_enb;
						pd_oe_next[k] = 1'b1;
					end
					if (k == PD_CLK)
						pd_oe_next[k] = 1'b1;
					if (k == PD_SOC) begin
						pd_out_next[k] = soc_tx;
						pd_oe_next[k] = soc_tx_en;
					end
				end
			end
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_data
			localparam int P = data_pin(i);
			logic drive;
			assign drive = cell_mode & portd_assign_reg[P];
			// data pins turn round with the core's enable
			always_comb begin
				rx_data_next[i] = drive ? pd_in[P] : 1'b0;
			end
		end
	endgenerate

	logic [15:3] pd_out_data;
	logic [15:3] pd_oe_data;

	always_comb begin
		pd_out_data = pd_out_next;
		pd_oe_data = pd_oe_next;
		for (int j = 0; j < 8; j++) begin
			if (cell_mode && portd_assign_reg[data_pin(j)]) begin
				pd_out_data[data_pin(j)] = cell_tx_data[j];
				pd_oe_data[data_pin(j)] = cell_tx_data_en;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// clock generator

	logic cell_clk_int;

	aps_clk_div u_div (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pow2_divider(sys_clock_control_reg[POW2_FIRST:POW2_LAST]),
		.odd_divider(sys_clock_control_reg[ODD_FIRST:ODD_LAST]),
		.cell_bus_clock(cell_clk_int)
	);

	// the clock itself cannot be retimed, so it bypasses the output flops
	logic pd_clk_sel_reg;
	logic [15:3] pd_out_reg;

	always_comb begin
		cell_bus_clock = cell_clk_int;
		pd_out = pd_out_reg;
		if (pd_clk_sel_reg)
			pd_out[PD_CLK] = cell_clk_int;
	end

	////////////////////////////////////////////////////////////////////////////
	// registered outputs

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pd_out_reg <= '0;
			pd_oe <= '0;
			pd_clk_sel_reg <= 1'b0;
			periph_pd_in <= '0;
			cell_rx_data <= '0;
			soc_rx <= 1'b0;
		end else begin
			pd_out_reg <= pd_out_data;
			pd_oe <= pd_oe_data;
			pd_clk_sel_reg <= cell_mode & portd_assign_reg[PD_CLK];
			periph_pd_in <= periph_next;
			cell_rx_data <= rx_data_next;
			soc_rx <= cell_mode & portd_assign_reg[PD_SOC] & pd_in[PD_SOC];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_cav <= 1'b0;
			rx_cav <= 1'b0;
			phy_request <= '0;
			pb_out <= '0;
			pb_oe <= '0;
		end else begin
			tx_cav <= portb_assign_reg[TXCAV_PIN] & ~portb_direction_reg[TXCAV_PIN]
				& pb_in[TXCAV_PIN];
			// the mask also hides the false pulse when mode bits are set
			rx_cav <= cell_mode & ~portc_assign_reg[RXCAV_PIN] & ~portc_direction_reg[RXCAV_PIN]
				& portc_special_option_reg[RXCAV_PIN] & ~cav_mask_reg & pc15_in;
			phy_request[0] <= mphy_req_ok & ~portb_assign_reg[16] & ~portb_direction_reg[16]
				& pb_in[16];
			phy_request[1] <= mphy_req_ok & ~portb_assign_reg[17] & ~portb_direction_reg[17]
				& pb_in[17];
			pb_oe[20] <= mphy_sel_ok & ~portb_assign_reg[20] & portb_direction_reg[20];
			pb_oe[21] <= mphy_sel_ok & ~portb_assign_reg[21] & portb_direction_reg[21];
			pb_out[20] <= core_phy_select[0];
			pb_out[21] <= core_phy_select[1];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sar_on <= 1'b0;
			cell_bus_mode <= 1'b0;
			request0_mode <= 1'b0;
			request1_mode <= 1'b0;
			request_priority <= '0;
			cell_ctrl_tx <= 1'b0;
			cell_ctrl_rx <= 1'b0;
			transparent_tx <= 1'b0;
			transparent_rx <= 1'b0;
			payload_whitening_on <= 1'b0;
			coset_on <= 1'b0;
			cell_sync_flag <= 1'b0;
		end else begin
			sar_on <= portd_assign_reg[SAR_BIT];
			cell_bus_mode <= cell_mode;
			request0_mode <= processor_config_reg[CFG_REQ0];
			request1_mode <= processor_config_reg[CFG_REQ1];
			request_priority <= processor_config_reg[CFG_PRIO_HI:CFG_PRIO_LO];
			cell_ctrl_tx <= serial_cell_cfg & channel_general_mode_reg[TX_ON_BIT];
			cell_ctrl_rx <= serial_cell_cfg & channel_general_mode_reg[RX_ON_BIT];
			transparent_tx <= ~serial_cell_cfg & channel_general_mode_reg[TX_ON_BIT]
				& (channel_general_mode_reg[MODE_HI:0] == TRANSPARENT_MODE);
			transparent_rx <= ~serial_cell_cfg & channel_general_mode_reg[RX_ON_BIT]
				& (channel_general_mode_reg[MODE_HI:0] == TRANSPARENT_MODE);
			payload_whitening_on <= serial_cell_cfg & protocol_mode_reg[WHITEN_BIT];
			coset_on <= serial_cell_cfg & protocol_mode_reg[COSET_BIT];
			cell_sync_flag <= sync_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port

	always_comb begin
		rdata_next = '0;
		if (hit(reg_addr, OFS_SYS_CLOCK_CONTROL))
			rdata_next = sys_clock_control_reg;
		else if (hit(reg_addr, OFS_PROTOCOL_MODE))
			rdata_next = {16'h0000, protocol_mode_reg};
		else if (hit(reg_addr, OFS_PORTB_ASSIGN))
			rdata_next = portb_assign_reg;
		else if (hit(reg_addr, OFS_PORTB_DIRECTION))
			rdata_next = portb_direction_reg;
		else if (hit(reg_addr, OFS_PORTC_ASSIGN))
			rdata_next = {16'h0000, portc_assign_reg};
		else if (hit(reg_addr, OFS_PORTC_DIRECTION))
			rdata_next = {16'h0000, portc_direction_reg};
		else if (hit(reg_addr, OFS_PORTC_SPECIAL_OPTION))
			rdata_next = {16'h0000, portc_special_option_reg};
		else if (hit(reg_addr, OFS_PORTD_ASSIGN))
			rdata_next = {16'h0000, portd_assign_reg};
		else if (hit(reg_addr, OFS_PORTD_DIRECTION))
			rdata_next = {16'h0000, portd_direction_reg};
		else if (hit(reg_addr, OFS_PORTD_DATA))
			rdata_next = {16'h0000, portd_data_reg};
		else if (hit(reg_addr, OFS_PROCESSOR_CONFIG))
			rdata_next = {28'h0000000, processor_config_reg};
		else if (hit(reg_addr, OFS_REFRESH_CONTROL))
			rdata_next = {31'h00000000, cav_mask_reg};
		else if (hit(reg_addr, OFS_CHANNEL_GENERAL_MODE))
			rdata_next = {26'h0000000, channel_general_mode_reg};
		else if (hit(reg_addr, OFS_MAX_RX_BUFFER_LEN))
			rdata_next = {16'h0000, max_rx_buffer_len_reg};
		else if (hit(reg_addr, OFS_CELL_STATUS))
			rdata_next = {28'h0000000, serial_cell_cfg, cell_mode,
				(settle_reg == '0), sync_reg};
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule

// File: aps_pkg.sv
// constants shared by the cell-bus port setup logic
package aps_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// register byte addresses
	localparam logic [11:0] OFS_SYS_CLOCK_CONTROL = 12'h280;
	localparam logic [11:0] OFS_PROTOCOL_MODE = 12'h284;
	localparam logic [11:0] OFS_PORTB_ASSIGN = 12'h288;
	localparam logic [11:0] OFS_PORTB_DIRECTION = 12'h28c;
	localparam logic [11:0] OFS_PORTC_ASSIGN = 12'h290;
	localparam logic [11:0] OFS_PORTC_DIRECTION = 12'h294;
	localparam logic [11:0] OFS_PORTC_SPECIAL_OPTION = 12'h298;
	localparam logic [11:0] OFS_PORTD_ASSIGN = 12'h29c;
	localparam logic [11:0] OFS_PORTD_DIRECTION = 12'h2a0;
	localparam logic [11:0] OFS_PORTD_DATA = 12'h2a4;
	localparam logic [11:0] OFS_PROCESSOR_CONFIG = 12'h2a8;
	localparam logic [11:0] OFS_REFRESH_CONTROL = 12'h2ac;
	localparam logic [11:0] OFS_CHANNEL_GENERAL_MODE = 12'h2b0;
	localparam logic [11:0] OFS_MAX_RX_BUFFER_LEN = 12'h2b4;
	localparam logic [11:0] OFS_CELL_STATUS = 12'h2b8;
	// reset values
	localparam logic [31:0] SYS_CLOCK_CONTROL_RST = 32'h0000_0000;
	localparam logic [15:0] PROTOCOL_MODE_RST = 16'h0000;
	// field positions, bit 0 is the msb of the register
	localparam int POW2_FIRST = 27;
	localparam int POW2_LAST = 29;
	localparam int ODD_FIRST = 30;
	localparam int ODD_LAST = 31;
	localparam int WHITEN_BIT = 2;
	localparam int COSET_BIT = 7;
	localparam int SAR_BIT = 0;
	localparam int CELL_SEL_BIT = 1;
	// divider codes and limits
	localparam logic [1:0] ODD_BY1 = 2'h0;
	localparam logic [1:0] ODD_BY3 = 2'h1;
	localparam logic [1:0] ODD_BY5 = 2'h2;
	localparam logic [2:0] POW2_MAX = 3'h2;
	localparam logic [4:0] FACTOR_1 = 5'h01;
	localparam logic [4:0] FACTOR_3 = 5'h03;
	localparam logic [4:0] FACTOR_5 = 5'h05;
	// pins
	localparam int TXCAV_PIN = 15;
	localparam int RXCAV_PIN = 15;
	localparam int PD_RXENB = 11;
	localparam int PD_TXENB = 10;
	localparam int PD_CLK = 9;
	localparam int PD_SOC = 3;
	localparam logic [15:3] PD_CELL_PINS = 13'h1fdf;
	localparam logic [15:3] PD_FORCE_LOW = 13'h1e00;
	localparam logic [15:3] PD_FORCE_HIGH = 13'h0007;
	// own-register fields
	localparam int CFG_REQ0 = 0;
	localparam int CFG_REQ1 = 1;
	localparam int CFG_PRIO_LO = 2;
	localparam int CFG_PRIO_HI = 3;
	localparam int MODE_HI = 3;
	localparam int TX_ON_BIT = 4;
	localparam int RX_ON_BIT = 5;
	// settle time between port D assignment and mask clear, system clocks
	localparam int SETTLE_CLOCKS = 20;
	localparam logic [4:0] SETTLE_CYC = 5'(SETTLE_CLOCKS);
endpackage

// File: aps_clk_div.sv
// cell-bus clock generator: power-of-two stage times odd stage
`timescale 1ns/10ps
module aps_clk_div (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [2:0] pow2_divider,
	input wire logic [1:0] odd_divider,
	output logic cell_bus_clock
);
	import aps_pkg::*;

	logic [2:0] pow2_eff;
	logic [4:0] odd_fac;
	logic [4:0] ratio;
	logic [4:0] half;
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	logic pos_reg;
	logic neg_reg;

	always_comb begin
		// factors above four are clamped rather than wrapped
		pow2_eff = (pow2_divider > POW2_MAX) ? POW2_MAX : pow2_divider;
		case (odd_divider)
			ODD_BY1: odd_fac = FACTOR_1;
			ODD_BY3: odd_fac = FACTOR_3;
			ODD_BY5: odd_fac = FACTOR_5;
			default: odd_fac = FACTOR_1;
		endcase
		ratio = 5'(odd_fac << pow2_eff);
		half = 5'((ratio + FACTOR_1) >> 1);
		cnt_next = (cnt_reg >= ratio - FACTOR_1) ? '0 : 5'(cnt_reg + FACTOR_1);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt_reg <= '0;
			pos_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			pos_reg <= (cnt_next < half);
		end
	end

	// half-cycle copy trims odd ratios back to an even duty
	always_ff @(negedge ref_clk) begin
		if (sys_rst) begin
			neg_reg <= 1'b0;
		end else begin
			neg_reg <= pos_reg;
		end
	end

	always_comb begin
		if (ratio == FACTOR_1) begin
			cell_bus_clock = ref_clk;
		end else if (ratio[0]) begin
			cell_bus_clock = pos_reg & neg_reg;
		end else begin
			cell_bus_clock = pos_reg;
		end
	end
endmodule

// File: aps_props.sv
// property checker for the cell-bus port setup block
`timescale 1ns/10ps
module aps_props (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [17:15] pb_in,
	input wire logic pc15_in,
	input wire logic [15:3] pd_in,
	input wire logic [15:3] periph_pd_in,
	input wire logic tx_cav,
	input wire logic rx_cav,
	input wire logic cell_bus_mode,
	input wire logic cell_ctrl_tx,
	input wire logic cell_ctrl_rx,
	input wire logic transparent_tx,
	input wire logic transparent_rx,
	input wire logic payload_whitening_on,
	input wire logic coset_on,
	input wire logic cell_sync_flag
);
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////
	// sync may trail the start-of-cell pin by one or two clocks
	sequence soc_seen;
		$past(pd_in[3]) || $past(pd_in[3], 2);
	endsequence
	sequence mode_left;
		$fell(cell_bus_mode);
	endsequence
	tx_cav_src_a: assert property (tx_cav |-> $past(pb_in[15]))
		else $error("tx cav without pin level");
	rx_cav_src_a: assert property (rx_cav |-> $past(pc15_in) && cell_bus_mode)
		else $error("rx cav without pin level or cell mode");
	periph_tie_a: assert property (cell_bus_mode && $past(cell_bus_mode) |->
		periph_pd_in[15:12] == 4'h0 && periph_pd_in[5:3] == 3'h7)
		else $error("displaced inputs not tied");
	no_mixed_a: assert property (!(cell_ctrl_tx && transparent_rx) &&
		!(cell_ctrl_rx && transparent_tx))
		else $error("mixed cell and plain channel");
	cell_or_plain_a: assert property (!(cell_ctrl_tx && transparent_tx) &&
		!(cell_ctrl_rx && transparent_rx))
		else $error("channel both cell and plain");
	whiten_scope_a: assert property ((payload_whitening_on || coset_on) |->
		cell_ctrl_tx && cell_ctrl_rx && !cell_bus_mode)
		else $error("cell options outside serial cell setup");
	sync_cause_a: assert property ($rose(cell_sync_flag) |-> soc_seen)
		else $error("sync without start of cell");
	sync_drop_a: assert property (mode_left |-> ##[0:2] !cell_sync_flag)
		else $error("sync kept after leaving cell mode");
endmodule
bind aps_port_setup aps_props aps_props_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .pb_in(pb_in),
	.pc15_in(pc15_in), .pd_in(pd_in), .periph_pd_in(periph_pd_in), .tx_cav(tx_cav),
	.rx_cav(rx_cav), .cell_bus_mode(cell_bus_mode), .cell_ctrl_tx(cell_ctrl_tx),
	.cell_ctrl_rx(cell_ctrl_rx), .transparent_tx(transparent_tx),
	.transparent_rx(transparent_rx), .payload_whitening_on(payload_whitening_on),
	.coset_on(coset_on), .cell_sync_flag(cell_sync_flag));

// File: aps_phy_model.sv
// behavioural line device driving cell data and start-of-cell on port D
`timescale 1ns/10ps
module aps_phy_model (
	input wire logic ref_clk,
	input wire logic [15:3] pd_out,
	input wire logic [15:3] pd_oe,
	input wire logic [7:0] phy_byte,
	input wire logic phy_soc,
	output logic [15:3] pd_in
);
	logic [15:3] phy_val;
	logic [15:3] last_reg = '0;
	// undriven pins wander so a stale level cannot pass for data
	always_comb begin
		phy_val = ~last_reg;
		for (int i = 0; i < 4; i++) begin
			phy_val[15 - i] = phy_byte[i];
			phy_val[7 - i] = phy_byte[4 + i];
		end
		phy_val[3] = phy_soc;
		pd_in = (pd_oe & pd_out) | (~pd_oe & phy_val);
	end
	always @(posedge ref_clk) last_reg <= pd_in;
endmodule

// File: test_atm_phy_port_setup.sv
// self-checking bench for the cell-bus port setup block
`timescale 1ns/10ps
module test_atm_phy_port_setup;
	import aps_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic [DATA_W-1:0] reg_rdata, b;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_seen = 1'b0;
	logic [17:15] pb_in = '0;
	logic pc15_in = 1'b0;
	logic [15:3] ser_pd_out = '0;
	logic [7:0] cell_tx_data = '0;
	logic [7:0] phy_byte = '0;
	logic tx_en = 1'b0;
	logic phy_soc = 1'b0;
	logic rx_enb = 1'b0;
	logic tx_enb = 1'b0;
	logic [1:0] phy_sel = '0;
	logic [21:20] pb_out, pb_oe;
	logic [15:3] pd_in, pd_out, pd_oe, periph_pd_in;
	logic [7:0] cell_rx_data;
	logic [1:0] phy_request, request_priority;
	logic tx_cav, rx_cav, soc_rx, cell_bus_clock, sar_on, cell_bus_mode, request0_mode;
	logic request1_mode, cell_ctrl_tx, cell_ctrl_rx, transparent_tx, transparent_rx;
	logic payload_whitening_on, coset_on, cell_sync_flag;
	logic [31:0] exp_q[$];
	int seed, err_total, checked;
	always #2 ref_clk = ~ref_clk;
	aps_port_setup #(.TRANSPARENT_MODE(4'h1)) aps_port_setup_i (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
		.pc15_in(pc15_in), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
		.cell_tx_data(cell_tx_data), .cell_tx_data_en(tx_en), .cell_rx_data(cell_rx_data),
		.soc_tx(1'b0), .soc_tx_en(1'b0), .soc_rx(soc_rx), .core_rx_enb(rx_enb),
		.core_tx_enb(tx_enb), .core_phy_select(phy_sel), .tx_cav(tx_cav), .rx_cav(rx_cav),
		.phy_request(phy_request), .ser_pd_out(ser_pd_out), .ser_pd_oe(13'h0),
		.periph_pd_in(periph_pd_in), .cell_bus_clock(cell_bus_clock), .sar_on(sar_on),
		.cell_bus_mode(cell_bus_mode), .request0_mode(request0_mode),
		.request1_mode(request1_mode), .request_priority(request_priority),
		.cell_ctrl_tx(cell_ctrl_tx), .cell_ctrl_rx(cell_ctrl_rx),
		.transparent_tx(transparent_tx), .transparent_rx(transparent_rx),
		.payload_whitening_on(payload_whitening_on), .coset_on(coset_on),
		.cell_sync_flag(cell_sync_flag));
	aps_phy_model aps_phy_model_i (.ref_clk(ref_clk), .pd_out(pd_out), .pd_oe(pd_oe),
		.phy_byte(phy_byte), .phy_soc(phy_soc), .pd_in(pd_in));
	////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// each access ends with an idle cycle so a strobe is never set twice in one step
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask
	always @(posedge ref_clk) rd_seen <= reg_rd;
	always @(negedge ref_clk) begin
		if (rd_seen && exp_q.size() == 0) chk("read queue", 32'h1, 32'h0);
		else if (rd_seen) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
	end
	task automatic wait_lvl(input logic v);
		int n;
		n = 0;
		while (cell_bus_clock !== v && n < 200) begin
			#0.5;
			n++;
		end
		if (n >= 200) err_total++;
		if (n >= 200) conclude();
	endtask
	// polling off the edge grid keeps the measured half periods exact
	task automatic clk_meas(input int f);
		realtime t0, t1, t2;
		repeat (12) @(posedge ref_clk);
		#0.25;
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		t0 = $realtime;
		wait_lvl(1'b0);
		t1 = $realtime;
		wait_lvl(1'b1);
		t2 = $realtime;
		chk("clock high ns", 2 * f, $rtoi(t1 - t0 + 0.1));
		chk("clock low ns", 2 * f, $rtoi(t2 - t1 + 0.1));
		@(posedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h345b7ccc;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rd(OFS_SYS_CLOCK_CONTROL, SYS_CLOCK_CONTROL_RST);
		rd(OFS_PROTOCOL_MODE, {16'h0, PROTOCOL_MODE_RST});
		rd(12'h3fc, 32'h0);
		clk_meas(1);
		for (int p = 0; p < 3; p++) begin
			for (int o = 0; o < 3; o++) begin
				if ((2 ** p) * (2 * o + 1) <= 5) begin
					b = {27'h0, 3'(p), 2'(o)};
					wr(OFS_SYS_CLOCK_CONTROL, b);
					rd(OFS_SYS_CLOCK_CONTROL, b);
					clk_meas((2 ** p) * (2 * o + 1));
				end
			end
		end
		wr(OFS_PORTD_ASSIGN, 32'h8000);
		wr(OFS_MAX_RX_BUFFER_LEN, 32'h0);
		wr(OFS_CHANNEL_GENERAL_MODE, 32'h31);
		wr(OFS_PROCESSOR_CONFIG, 32'h6);
		for (int k = 3; k >= 0; k--) begin
			b = {18'h0, k[0], 4'h0, k[1], 8'h0};
			wr(OFS_PROTOCOL_MODE, b);
			rd(OFS_PROTOCOL_MODE, b);
			chk("whitening", b[13], payload_whitening_on);
			chk("coset", b[8], coset_on);
		end
		chk("cell ctrl", 32'h6, {cell_ctrl_tx, cell_ctrl_rx, cell_bus_mode});
		chk("serial request", 32'h5, {request1_mode, request_priority});
		wr(OFS_MAX_RX_BUFFER_LEN, 32'h40);
		@(posedge ref_clk);
		chk("plain channel", 32'hc, {transparent_tx, transparent_rx, cell_ctrl_tx, cell_ctrl_rx});
		wr(OFS_REFRESH_CONTROL, 32'h1);
		wr(OFS_PORTD_ASSIGN, 32'hdfff);
		rd(OFS_CELL_STATUS, 32'h4);
		wr(OFS_PORTD_DIRECTION, 32'h0);
		wr(OFS_PORTC_ASSIGN, 32'h0);
		wr(OFS_PORTC_DIRECTION, 32'h0);
		wr(OFS_PORTC_SPECIAL_OPTION, 32'h1);
		wr(OFS_PORTB_ASSIGN, 32'h0001_0000);
		wr(OFS_PORTB_DIRECTION, 32'h0000_0c00);
		wr(OFS_PROCESSOR_CONFIG, 32'h7);
		pc15_in <= 1'b1;
		repeat (SETTLE_CLOCKS) @(posedge ref_clk);
		chk("masked rx cav", 32'h0, rx_cav);
		chk("cell mode", 32'h3, {sar_on, cell_bus_mode});
		chk("cell request", 32'hd, {request0_mode, request1_mode, request_priority});
		chk("select drive", 32'h3, pb_oe);
		wr(OFS_REFRESH_CONTROL, 32'h0);
		@(posedge ref_clk);
		chk("no sync yet", 32'h0, cell_sync_flag);
		rd(OFS_CELL_STATUS, 32'h6);
		for (int n = 0; n < 4; n++) begin
			b = $random(seed);
			{pc15_in, pb_in, cell_tx_data, phy_byte} <= b[19:0];
			{phy_sel, tx_enb, rx_enb} <= b[23:20];
			ser_pd_out <= b[31:19];
			tx_en <= 1'b0;
			repeat (3) @(posedge ref_clk);
			chk("rx data", b[7:0], cell_rx_data);
			chk("tx cav", b[16], tx_cav);
			chk("rx cav", b[19], rx_cav);
			chk("enables", {b[20], b[21]}, pd_out[11:10]);
			chk("ctrl drive", 32'h7, pd_oe[11:9]);
			chk("phy request", {b[18], b[17]}, phy_request);
			chk("phy select", b[23:22], pb_out);
			chk("tied inputs", 32'h7, {periph_pd_in[15:12], periph_pd_in[5:3]});
			tx_en <= 1'b1;
			repeat (3) @(posedge ref_clk);
			chk("tx data hi", {b[8], b[9], b[10], b[11]}, pd_out[15:12]);
			chk("tx data lo", {b[12], b[13], b[14], b[15]}, pd_out[7:4]);
			chk("tx data oe", 32'hf0f, {pd_oe[15:12], 4'h0, pd_oe[7:4]});
		end
		tx_en <= 1'b0;
		phy_soc <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk("soc in", 32'h1, soc_rx);
		phy_soc <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("sync found", 32'h1, cell_sync_flag);
		wr(OFS_PORTD_ASSIGN, 32'h0);
		repeat (2) @(posedge ref_clk);
		chk("sync cleared", 32'h0, cell_sync_flag);
		conclude();
	end
endmodule
